// ---- closed_loop_cfg.svh ----
// constants for closed-loop test mode gating
`ifndef CLOSED_LOOP_CFG_SVH
`define CLOSED_LOOP_CFG_SVH
`define PRODUCT_MODE_OFF 16'h0000
`define PRODUCT_MODE_ON 16'h0001
`define PRODUCT_MODE_TEST 16'h0002
`define PARAM_UNSET 16'h270F
`define METHOD_VECTOR 16'h0000
`define METHOD_VECTOR_TEST 16'h0009
`define COMM_SOURCE_NET 16'h0000
`define COMM_STOP_MODE_FIXED 16'h0000
`define FREQ_CEILING_HZ 200
`define FREQ_UNIT_PER_HZ 100
`define FREQ_CEILING (16'(`FREQ_CEILING_HZ * `FREQ_UNIT_PER_HZ))
`define FREQ_FLOOR 16'h0001
`define FREQ_ZERO 16'h0000
`define VSPEED_BASE_SHIFT 4
`endif

// ---- closed_loop_pkg.sv ----
// types shared by the closed-loop test mode gating block
package closed_loop_pkg;
	// monitor item selector codes
	typedef enum logic [3:0] {
		MON_CRANE_SPEED = 4'h0,
		MON_MODEL_SPEED = 4'h1,
		MON_CMD_AFTER_LOOP = 4'h2,
		MON_CMD_CREATED = 4'h3,
		MON_CMD_AFTER_DROOP = 4'h4,
		MON_COMP_TOTAL = 4'h5,
		MON_POS_CMD_LO = 4'h6,
		MON_POS_CMD_HI = 4'h7,
		MON_CUR_POS_LO = 4'h8,
		MON_CUR_POS_HI = 4'h9,
		MON_FAIL_CODE = 4'hA,
		MON_OUT_CURRENT = 4'hB,
		MON_OUT_VOLTAGE = 4'hC
	} monitor_item_e;
	// crane position inputs
	typedef struct packed {
		logic limit_dog_input;
		logic second_limit_dog_input;
		logic fork_select_input;
		logic feed_type_switch_input;
		logic accel_pattern_select_input;
		logic crane_emergency_stop_input;
		logic product_mode_input;
	} crane_inputs_s;
	// raw monitor values from the drive core
	typedef struct packed {
		logic [15:0] model_speed;
		logic [15:0] cmd_after_loop;
		logic [15:0] cmd_created;
		logic [15:0] cmd_after_droop;
		logic [15:0] comp_total;
		logic [31:0] position_command;
		logic [31:0] current_position;
		logic [15:0] fail_code;
		logic [15:0] out_current;
		logic [15:0] out_voltage;
		logic [15:0] measured_speed;
	} monitor_s;
	// raw output signals from the drive core
	typedef struct packed {
		logic brake_open_request;
		logic system_failure_output;
		logic position_level_notify;
		logic in_position_notify;
		logic out_of_position_output;
		logic in_position_output;
		logic current_related_output;
	} crane_outputs_s;
	// standard functions forced off under closed-loop control
	typedef struct packed {
		logic min_frequency;
		logic start_hold;
		logic jog;
		logic stop_on_contact;
		logic power_fail_restart;
		logic load_torque_high_speed;
		logic encoder_feedback;
		logic start_self_hold;
		logic multi_speed;
		logic analog_input;
		logic analog_compensation;
		logic pulse_train_input;
		logic overspeed_detect;
	} function_disable_s;
endpackage

// ---- closed_loop_gate.sv ----
// gating and restriction logic for full-closed position control and its test mode
//
// Overview of operation
// [RL1] Test mode needs product mode parameter 2
// [RL2] Fork select and second motor inactive
// [RL3] Capacity, poles set; control method is 9
// [RL4] Reference travel speed not the sentinel
// [RL5] Product mode input signal must be active
// [RL6] Network mode with both command sources zero
// [RL7] No current or voltage monitoring in test
// [RL8] Virtual speed follows load inertia ratio
// [RL9] Test disables dual feedback, meter failures
// [RL10] Test keeps brake open request inactive
// [RL11] Crane inputs stay functional during test
// [RL12] Position and failure items panel only
// [RL13] Speed items on panel and analog
// [RL14] Closed loop disables listed standard functions
// [RL15] Frequency ceiling clamped to 200 Hz
// [RL16] Zero minimum frequency becomes 0.01 Hz
// [RL17] Communication error stop mode forced zero
// [RL18] DC brake, starting frequency fixed zero
// [RL19] Emergency stop uses closed-loop decel time
// [RL20] Pre-excite, DC brake only method 0
// [RL21] Frequency command treated as unsigned
// [RL22] Test enable re-evaluated every clk_en cycle
`timescale 1ns/1ps
`default_nettype none
`include "closed_loop_cfg.svh"

module closed_loop_gate
	import closed_loop_pkg::*;
#(
	parameter int SPEED_W = 16
) (
	// clock, reset and enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// parameter settings
	input wire logic [15:0] product_mode_param,
	input wire logic [15:0] motor_capacity_param,
	input wire logic [15:0] motor_poles_param,
	input wire logic [15:0] control_method_param,
	input wire logic [15:0] reference_travel_speed_param,
	input wire logic [15:0] comm_operation_source_param,
	input wire logic [15:0] comm_speed_source_param,
	input wire logic [15:0] load_inertia_ratio_param,
	input wire logic [15:0] max_frequency_param,
	input wire logic [15:0] high_speed_max_frequency_param,
	input wire logic [15:0] min_frequency_param,
	input wire logic [15:0] comm_error_stop_mode_param,
	input wire logic [15:0] dc_brake_frequency_param,
	input wire logic [15:0] starting_frequency_param,
	input wire logic [15:0] emergency_decel_time_param,
	input wire logic [15:0] closed_loop_decel_time_param,
	input wire logic frequency_sign_select_param,
	// drive status and commands
	input wire logic network_mode,
	input wire logic second_motor_select,
	input wire logic drive_running,
	input wire logic emergency_stop_input,
	input wire logic pre_excitation_input,
	input wire logic external_dc_brake_start,
	input wire logic signed [SPEED_W-1:0] frequency_command,
	input wire logic distance_meter_fault,
	input wire logic distance_meter_alarm,
	input wire logic overspeed_raw,
	input wire crane_inputs_s crane_inputs,
	input wire crane_outputs_s crane_outputs_raw,
	input wire monitor_s monitor_raw,
	// monitor item selection
	input wire monitor_item_e panel_item,
	input wire monitor_item_e first_analog_item,
	input wire monitor_item_e second_analog_item,
	// mode status
	output logic closed_loop_enabled,
	output logic test_mode_active,
	output logic dual_feedback_enable,
	output function_disable_s function_disable,
	// effective settings
	output logic [15:0] eff_max_frequency,
	output logic [15:0] eff_high_speed_max_frequency,
	output logic [15:0] eff_min_frequency,
	output logic [15:0] eff_comm_error_stop_mode,
	output logic [15:0] eff_dc_brake_frequency,
	output logic [15:0] eff_starting_frequency,
	output logic [15:0] eff_emergency_decel_time,
	output logic [SPEED_W-1:0] freq_command_out,
	output logic freq_command_negative,
	// gated signals
	output logic pre_excitation_active,
	output logic dc_brake_start_active,
	output logic emergency_stop_decel,
	output logic system_failure_detect,
	output logic overspeed_fault,
	output crane_inputs_s crane_inputs_valid,
	output crane_outputs_s crane_outputs,
	// virtual plant and monitors
	output logic signed [SPEED_W-1:0] virtual_speed,
	output logic signed [31:0] virtual_position,
	output logic [15:0] panel_monitor,
	output logic [15:0] first_analog_output,
	output logic [15:0] second_analog_output
);

	// ==========================================================
	// state
	// ==========================================================
	typedef struct packed {
		logic closed;                        // closed-loop control on
		logic test;                          // test mode on
		logic dual_fb;                       // dual feedback allowed
		function_disable_s fdis;             // disabled functions
		logic [15:0] max_f;                  // clamped ceiling
		logic [15:0] hs_max_f;               // clamped high-speed ceiling
		logic [15:0] min_f;                  // lower limit
		logic [15:0] comm_stop;              // comm error stop mode
		logic [15:0] dc_f;                   // dc brake frequency
		logic [15:0] start_f;                // starting frequency
		logic [15:0] estop_decel;            // decel time on emergency stop
		logic [SPEED_W-1:0] fcmd;            // frequency command out
		logic fneg;                          // command sign
		logic preex;                         // pre-excitation allowed
		logic dcb;                           // dc brake start allowed
		logic estop;                         // emergency stop decel active
		logic sysfail;                       // system failure detect
		logic ovs;                           // overspeed fault
		crane_inputs_s cin;                  // passed inputs
		crane_outputs_s cout;                // gated outputs
		logic signed [SPEED_W-1:0] vspeed;   // virtual speed
		logic signed [31:0] vpos;            // virtual position
		logic [15:0] panel;                  // panel monitor value
		logic [15:0] ana1;                   // first analog value
		logic [15:0] ana2;                   // second analog value
	} gate_state_s;

	gate_state_s state_reg;
	gate_state_s state_next;

	// ==========================================================
	// helper functions
	// ==========================================================
	// clamp a frequency ceiling to the closed-loop limit
	function automatic logic [15:0] clamp_ceiling(input logic [15:0] f);
		clamp_ceiling = (f > `FREQ_CEILING) ? `FREQ_CEILING : f;
	endfunction

	// inertia ratio to extra shift: larger load settles slower
	function automatic logic [4:0] inertia_shift(input logic [15:0] ratio);
		logic [4:0] s;
		s = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (ratio[i]) begin
				s = 5'(i + 1);
			end
		end
		inertia_shift = s;
	endfunction

	// monitor item lookup with test-mode restrictions
	function automatic logic [15:0] pick_item(input monitor_item_e item, input monitor_s m,
		input logic signed [SPEED_W-1:0] vs, input logic test, input logic analog);
		logic [15:0] v;
		logic panel_only;
		v = 16'h0000;
		panel_only = 1'b0;
		case (item)
			MON_CRANE_SPEED: v = test ? 16'(vs) : m.measured_speed; // RL13
			MON_MODEL_SPEED: v = test ? 16'(vs) : m.model_speed;
			MON_CMD_AFTER_LOOP: v = m.cmd_after_loop;
			MON_CMD_CREATED: v = m.cmd_created;
			MON_CMD_AFTER_DROOP: v = m.cmd_after_droop;
			MON_COMP_TOTAL: begin
				v = m.comp_total;
				panel_only = 1'b1; // RL12
			end
			MON_POS_CMD_LO: begin
				v = m.position_command[15:0];
				panel_only = 1'b1; // RL12
			end
			MON_POS_CMD_HI: begin
				v = m.position_command[31:16];
				panel_only = 1'b1; // RL12
			end
			MON_CUR_POS_LO: begin
				v = m.current_position[15:0];
				panel_only = 1'b1; // RL12
			end
			MON_CUR_POS_HI: begin
				v = m.current_position[31:16];
				panel_only = 1'b1; // RL12
			end
			MON_FAIL_CODE: begin
				v = m.fail_code;
				panel_only = 1'b1; // RL12
			end
			MON_OUT_CURRENT: v = test ? 16'h0000 : m.out_current; // RL7
			MON_OUT_VOLTAGE: v = test ? 16'h0000 : m.out_voltage; // RL7
			default: v = 16'h0000;
		endcase
		if (test && analog && panel_only) begin
			v = 16'h0000; // RL12
		end
		pick_item = v;
	endfunction

	// ==========================================================
	// next-state logic
	// ==========================================================
	always_comb begin
		logic cl;
		logic tm;
		logic signed [SPEED_W-1:0] err;
		logic [4:0] sh;
		logic [SPEED_W-1:0] mag;
		cl = 1'b0;
		tm = 1'b0;
		err = '0;
		sh = 5'h00;
		mag = '0;
		state_next = state_reg;
		// closed loop runs when the product mode is on or test (1 or 2) and fork select is off
		cl = (product_mode_param == `PRODUCT_MODE_ON || product_mode_param == `PRODUCT_MODE_TEST)
			&& !crane_inputs.fork_select_input;
		// all conditions combined freshly every cycle
		tm = (product_mode_param == `PRODUCT_MODE_TEST) // RL1
			&& !crane_inputs.fork_select_input && !second_motor_select // RL2
			&& motor_capacity_param != `PARAM_UNSET && motor_poles_param != `PARAM_UNSET // RL3
			&& control_method_param == `METHOD_VECTOR_TEST // RL3
			&& reference_travel_speed_param != `PARAM_UNSET // RL4
			&& crane_inputs.product_mode_input // RL5
			&& network_mode && comm_operation_source_param == `COMM_SOURCE_NET // RL6
			&& comm_speed_source_param == `COMM_SOURCE_NET; // RL6
		state_next.closed = cl;
		state_next.test = tm; // RL22
		state_next.dual_fb = cl && !tm; // RL9
		// standard functions forced off
		state_next.fdis = cl ? '1 : '0; // RL14
		// effective settings
		if (cl) begin
			state_next.max_f = clamp_ceiling(max_frequency_param); // RL15
			state_next.hs_max_f = clamp_ceiling(high_speed_max_frequency_param); // RL15
			state_next.min_f = (min_frequency_param == `FREQ_ZERO) ? `FREQ_FLOOR
				: min_frequency_param; // RL16
			state_next.comm_stop = `COMM_STOP_MODE_FIXED; // RL17
			state_next.dc_f = `FREQ_ZERO; // RL18
			state_next.start_f = `FREQ_ZERO; // RL18
			state_next.estop_decel = closed_loop_decel_time_param; // RL19
		end else begin
			state_next.max_f = max_frequency_param;
			state_next.hs_max_f = high_speed_max_frequency_param;
			state_next.min_f = min_frequency_param;
			state_next.comm_stop = comm_error_stop_mode_param;
			state_next.dc_f = dc_brake_frequency_param;
			state_next.start_f = starting_frequency_param;
			state_next.estop_decel = emergency_decel_time_param;
		end
		// frequency command sign handling
		mag = frequency_command[SPEED_W-1] ? SPEED_W'(-frequency_command)
			: SPEED_W'(frequency_command);
		if (cl) begin
			state_next.fcmd = SPEED_W'(frequency_command); // RL21
			state_next.fneg = 1'b0; // RL21
		end else if (frequency_sign_select_param) begin
			state_next.fcmd = mag;
			state_next.fneg = frequency_command[SPEED_W-1];
		end else begin
			state_next.fcmd = SPEED_W'(frequency_command);
			state_next.fneg = 1'b0;
		end
		// pre-excitation and dc brake start in closed loop only under plain vector control
		state_next.preex = pre_excitation_input
			&& (!cl || control_method_param == `METHOD_VECTOR); // RL20
		state_next.dcb = external_dc_brake_start
			&& (!cl || (control_method_param == `METHOD_VECTOR && !drive_running)); // RL20
		state_next.estop = emergency_stop_input; // RL19
		// meter failures ignored in test
		state_next.sysfail = !tm && (distance_meter_fault || distance_meter_alarm); // RL9
		state_next.ovs = overspeed_raw && !cl; // RL14
		// crane inputs pass unchanged, also during test
		state_next.cin = crane_inputs; // RL11
		// outputs: brake request and current outputs blocked in test
		state_next.cout = crane_outputs_raw;
		if (tm) begin
			state_next.cout.brake_open_request = 1'b0; // RL10
			state_next.cout.current_related_output = 1'b0; // RL7
		end
		// virtual plant tracks the command, slowed by load inertia
		if (tm) begin
			err = SPEED_W'(frequency_command - state_reg.vspeed);
			sh = 5'(`VSPEED_BASE_SHIFT) + inertia_shift(load_inertia_ratio_param); // RL8
			state_next.vspeed = state_reg.vspeed + (err >>> sh); // RL8
			state_next.vpos = state_reg.vpos + 32'(state_reg.vspeed);
		end else begin
			state_next.vspeed = '0;
			state_next.vpos = 32'sh0;
		end
		// monitor routing
		state_next.panel = pick_item(panel_item, monitor_raw, state_reg.vspeed, tm, 1'b0);
		state_next.ana1 = pick_item(first_analog_item, monitor_raw, state_reg.vspeed, tm,
			1'b1); // RL13
		state_next.ana2 = pick_item(second_analog_item, monitor_raw, state_reg.vspeed, tm,
			1'b1); // RL13
	end

	// ==========================================================
	// state register
	// ==========================================================
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign closed_loop_enabled = state_reg.closed;
	assign test_mode_active = state_reg.test;
	assign dual_feedback_enable = state_reg.dual_fb;
	assign function_disable = state_reg.fdis;
	assign eff_max_frequency = state_reg.max_f;
	assign eff_high_speed_max_frequency = state_reg.hs_max_f;
	assign eff_min_frequency = state_reg.min_f;
	assign eff_comm_error_stop_mode = state_reg.comm_stop;
	assign eff_dc_brake_frequency = state_reg.dc_f;
	assign eff_starting_frequency = state_reg.start_f;
	assign eff_emergency_decel_time = state_reg.estop_decel;
	assign freq_command_out = state_reg.fcmd;
	assign freq_command_negative = state_reg.fneg;
	assign pre_excitation_active = state_reg.preex;
	assign dc_brake_start_active = state_reg.dcb;
	assign emergency_stop_decel = state_reg.estop;
	assign system_failure_detect = state_reg.sysfail;
	assign overspeed_fault = state_reg.ovs;
	assign crane_inputs_valid = state_reg.cin;
	assign crane_outputs = state_reg.cout;
	assign virtual_speed = state_reg.vspeed;
	assign virtual_position = state_reg.vpos;
	assign panel_monitor = state_reg.panel;
	assign first_analog_output = state_reg.ana1;
	assign second_analog_output = state_reg.ana2;

endmodule // closed_loop_gate

`default_nettype wire

// ---- closed_loop_gate_checker.sv ----
// assertions on the closed-loop gating block ports
`timescale 1ns/1ps
`default_nettype none
module closed_loop_gate_checker
	import closed_loop_pkg::*;
(
	// clock, reset and watched inputs
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [15:0] product_mode_param,
	input wire logic second_motor_select,
	input wire crane_inputs_s crane_inputs,
	input wire monitor_item_e first_analog_item,
	// watched outputs
	input wire logic closed_loop_enabled,
	input wire logic test_mode_active,
	input wire logic dual_feedback_enable,
	input wire function_disable_s function_disable,
	input wire logic [15:0] eff_max_frequency,
	input wire logic [15:0] eff_high_speed_max_frequency,
	input wire logic [15:0] eff_min_frequency,
	input wire logic [15:0] eff_comm_error_stop_mode,
	input wire logic [15:0] eff_dc_brake_frequency,
	input wire logic [15:0] eff_starting_frequency,
	input wire logic freq_command_negative,
	input wire crane_outputs_s crane_outputs,
	input wire logic [15:0] first_analog_output
);
	// ==========
	// test mode entry and gating
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_mode; clk_en && product_mode_param != 16'h0002 |=> !test_mode_active; endproperty
	a_mode: assert property (p_mode) else $error("test mode without mode two");
	property p_fork; clk_en && (crane_inputs.fork_select_input || second_motor_select)
		|=> !test_mode_active; endproperty
	a_fork: assert property (p_fork) else $error("test mode with fork or motor two");
	property p_brake; test_mode_active |-> !crane_outputs.brake_open_request; endproperty
	a_brake: assert property (p_brake) else $error("brake request in test");
	property p_dual; test_mode_active |-> !dual_feedback_enable && closed_loop_enabled; endproperty
	a_dual: assert property (p_dual) else $error("dual feedback in test");
	property p_panel; $past(clk_en) && test_mode_active
		&& $past(first_analog_item) inside {[MON_COMP_TOTAL:MON_FAIL_CODE]}
		|-> first_analog_output == 16'h0000; endproperty
	a_panel: assert property (p_panel) else $error("panel item on analog");
	// ==========
	// closed-loop restrictions
	property p_off; closed_loop_enabled |-> function_disable == 13'h1FFF; endproperty
	a_off: assert property (p_off) else $error("function left on");
	property p_ceil; closed_loop_enabled |-> eff_max_frequency <= 16'h4E20
		&& eff_high_speed_max_frequency <= 16'h4E20; endproperty
	a_ceil: assert property (p_ceil) else $error("frequency above ceiling");
	property p_floor; closed_loop_enabled |-> eff_min_frequency != 16'h0000; endproperty
	a_floor: assert property (p_floor) else $error("zero lower limit");
	property p_stop; closed_loop_enabled |-> eff_comm_error_stop_mode == 16'h0000; endproperty
	a_stop: assert property (p_stop) else $error("stop mode not zero");
	property p_dc; closed_loop_enabled |-> {eff_dc_brake_frequency, eff_starting_frequency}
		== 32'h0000_0000; endproperty
	a_dc: assert property (p_dc) else $error("brake or start frequency not zero");
	property p_sign; closed_loop_enabled |-> !freq_command_negative; endproperty
	a_sign: assert property (p_sign) else $error("signed command in closed loop");
endmodule // closed_loop_gate_checker
bind closed_loop_gate closed_loop_gate_checker chk (.*);
`default_nettype wire

// ---- host_model.sv ----
// host controller model for the network command side
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// intent from the bench
	input wire logic online,
	input wire logic bad_src,
	input wire logic [15:0] speed_ref,
	// network commands into the drive
	output logic network_mode,
	output logic [15:0] comm_operation_source_param,
	output logic [15:0] comm_speed_source_param,
	output logic signed [15:0] frequency_command
);
	// ==========
	// command mapping, one wrong source on request
	always_comb begin
		network_mode = online;
		comm_operation_source_param = 16'h0000;
		comm_speed_source_param = {15'h0000, bad_src};
		frequency_command = speed_ref;
	end
endmodule // host_model
`default_nettype wire

// ---- closed_loop_gate_test.sv ----
// self-checking bench for the closed-loop gating block
`timescale 1ns/1ps
`default_nettype none
module closed_loop_gate_test;
	import closed_loop_pkg::*;
	// ==========
	// signals
	typedef struct packed {logic [7:0] s; logic [31:0] e;} note_s;
	logic clk_sys = 0, reset_n = 0, clk_en = 1, online, bad_src;
	logic [15:0] product_mode_param, motor_capacity_param, motor_poles_param, speed_ref;
	logic [15:0] control_method_param, reference_travel_speed_param, load_inertia_ratio_param;
	logic [15:0] max_frequency_param, high_speed_max_frequency_param, min_frequency_param;
	logic [15:0] comm_error_stop_mode_param, dc_brake_frequency_param, starting_frequency_param;
	logic [15:0] emergency_decel_time_param, closed_loop_decel_time_param;
	logic [15:0] comm_operation_source_param, comm_speed_source_param;
	logic frequency_sign_select_param, network_mode, second_motor_select, drive_running;
	logic emergency_stop_input, pre_excitation_input, external_dc_brake_start, overspeed_raw;
	logic distance_meter_fault, distance_meter_alarm, closed_loop_enabled, test_mode_active;
	logic signed [15:0] frequency_command, virtual_speed;
	logic signed [31:0] virtual_position;
	crane_inputs_s crane_inputs, crane_inputs_valid;
	crane_outputs_s crane_outputs_raw, crane_outputs;
	monitor_s monitor_raw;
	monitor_item_e panel_item, first_analog_item, second_analog_item;
	function_disable_s function_disable;
	logic dual_feedback_enable, freq_command_negative, pre_excitation_active, overspeed_fault;
	logic dc_brake_start_active, emergency_stop_decel, system_failure_detect;
	logic [15:0] eff_max_frequency, eff_high_speed_max_frequency, eff_min_frequency;
	logic [15:0] eff_comm_error_stop_mode, eff_dc_brake_frequency, eff_starting_frequency;
	logic [15:0] eff_emergency_decel_time, freq_command_out, panel_monitor;
	logic [15:0] first_analog_output, second_analog_output;
	int seed = 81, bad_count = 0, compares = 0;
	int brk [10] = '{1, 2, 2, 3, 3, 3, 4, 5, 6, 6};
	int cl_exp [12] = '{32'h3FFF, 0, 32'h4E20, 32'h4E20, 1, 0, 0, 32'h0200, 1, 1, 1, 32'hFFFB};
	note_s q [$];
	note_s n;
	closed_loop_gate uut (.*);
	host_model host (.online(online), .bad_src(bad_src), .speed_ref(speed_ref),
		.network_mode(network_mode), .comm_operation_source_param(comm_operation_source_param),
		.comm_speed_source_param(comm_speed_source_param), .frequency_command(frequency_command));
	always #2 clk_sys = ~clk_sys;
	// ==========
	// helpers
	task automatic ck(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic nt(input int s, input logic [31:0] e);
		q.push_back('{8'(s), e});
	endtask
	task automatic cyc();
		@(posedge clk_sys);
		#1;
	endtask
	// all test conditions met, random legal settings
	task automatic arm();
		{online, bad_src, second_motor_select} = 3'b100;
		{crane_inputs.fork_select_input, crane_inputs.product_mode_input} = 2'b01;
		{product_mode_param, control_method_param} = {16'h0002, 16'h0009};
		{motor_capacity_param, motor_poles_param, reference_travel_speed_param} =
			48'({$random(seed), $random(seed)}) & {3{16'h0FFF}};
	endtask
	// virtual speed step from rest with a given inertia
	task automatic vs_try(input logic [15:0] inr, input logic [31:0] e);
		product_mode_param = 16'h0000;
		cyc();
		arm();
		speed_ref = 16'h0000;
		cyc();
		{load_inertia_ratio_param, speed_ref} = {inr, 16'h4000};
		nt(18, e);
		cyc();
		nt(31, e);
		cyc();
	endtask
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========
	// result watcher
	always begin
		@(posedge clk_sys);
		#0.5;
		while (q.size() > 0) begin
			n = q.pop_front();
			case (n.s)
				1: ck(32'(test_mode_active), n.e);
				2: ck(32'(test_mode_active), n.e);
				3: ck(32'(test_mode_active), n.e);
				4: ck(32'(test_mode_active), n.e);
				5: ck(32'(test_mode_active), n.e);
				6: ck(32'(test_mode_active), n.e);
				7: ck(32'(test_mode_active), n.e);
				8: ck(32'(crane_outputs.brake_open_request), n.e);
				9: ck(32'(crane_outputs), n.e);
				10: ck(32'(crane_outputs.current_related_output), n.e);
				11: ck(32'(panel_monitor), n.e);
				12: ck(32'(dual_feedback_enable), n.e);
				13: ck(32'(system_failure_detect), n.e);
				14: ck(32'(crane_inputs_valid), n.e);
				15: ck(32'(first_analog_output), n.e);
				16: ck(32'(panel_monitor), n.e);
				17: ck(32'(second_analog_output), n.e);
				18: ck(32'(virtual_speed), n.e);
				19: ck(32'({closed_loop_enabled, function_disable}), n.e);
				20: ck(32'(overspeed_fault), n.e);
				21: ck(32'(eff_max_frequency), n.e);
				22: ck(32'(eff_high_speed_max_frequency), n.e);
				23: ck(32'(eff_min_frequency), n.e);
				24: ck(32'(eff_comm_error_stop_mode), n.e);
				25: ck({eff_dc_brake_frequency, eff_starting_frequency}, n.e);
				26: ck(32'(eff_emergency_decel_time), n.e);
				27: ck(32'(emergency_stop_decel), n.e);
				28: ck(32'(pre_excitation_active), n.e);
				29: ck(32'(dc_brake_start_active), n.e);
				31: ck(virtual_position, n.e);
				default: ck(32'({freq_command_negative, freq_command_out}), n.e);
			endcase
		end
	end
	// watchdog on the whole run
	initial begin
		repeat (4000) @(posedge clk_sys);
		bad_count++;
		tally_and_finish();
	end
	// ==========
	// main sequence
	initial begin
		panel_item = MON_CRANE_SPEED;
		first_analog_item = MON_CRANE_SPEED;
		second_analog_item = MON_CRANE_SPEED;
		{crane_inputs, crane_outputs_raw, monitor_raw} = 222'h0;
		{max_frequency_param, high_speed_max_frequency_param, min_frequency_param} = 48'h0;
		{comm_error_stop_mode_param, dc_brake_frequency_param, starting_frequency_param,
			emergency_decel_time_param, closed_loop_decel_time_param} = 80'h0;
		{load_inertia_ratio_param, speed_ref} = 32'h0001_0000;
		{frequency_sign_select_param, drive_running, emergency_stop_input, pre_excitation_input,
			external_dc_brake_start, distance_meter_fault, distance_meter_alarm, overspeed_raw} = 8'h00;
		arm();
		repeat (16) @(posedge clk_sys);
		#1;
		reset_n = 1;
		nt(1, 1);
		cyc();
		// drop each condition but the operation source in turn, then recover
		for (int k = 0; k < 10; k++) begin
			arm();
			nt(7, 1);
			cyc();
			case (k)
				0: product_mode_param = 16'h0001;
				1: crane_inputs.fork_select_input = 1;
				2: second_motor_select = 1;
				3: motor_capacity_param = 16'h270F;
				4: motor_poles_param = 16'h270F;
				5: control_method_param = 16'h0000;
				6: reference_travel_speed_param = 16'h270F;
				7: crane_inputs.product_mode_input = 0;
				8: online = 0;
				default: bad_src = 1;
			endcase
			nt(brk[k], 0);
			cyc();
		end
		// outputs, inputs and monitors in test
		arm();
		crane_outputs_raw = 7'h7F;
		crane_inputs = 7'($random(seed)) & 7'h6F | 7'h01;
		monitor_raw = 208'({7{$random(seed)}});
		{monitor_raw.fail_code, monitor_raw.out_current} = 32'h00A5_1234;
		{distance_meter_fault, distance_meter_alarm} = 2'b11;
		panel_item = MON_OUT_CURRENT;
		first_analog_item = MON_FAIL_CODE;
		second_analog_item = MON_CMD_AFTER_LOOP;
		nt(8, 0);
		nt(9, 32'h3E);
		nt(10, 0);
		nt(11, 0);
		nt(12, 0);
		nt(13, 0);
		nt(14, 32'(crane_inputs));
		nt(15, 0);
		nt(17, 32'(monitor_raw.cmd_after_loop));
		cyc();
		panel_item = MON_FAIL_CODE;
		nt(16, 32'h00A5);
		cyc();
		vs_try(16'h0001, 32'h0200);
		vs_try(16'h0100, 32'h0002);
		// closed loop outside test
		{product_mode_param, control_method_param} = 32'h0001_0000;
		{max_frequency_param, high_speed_max_frequency_param, min_frequency_param} =
			48'hFFFF_4E21_0000;
		{comm_error_stop_mode_param, dc_brake_frequency_param, starting_frequency_param,
			emergency_decel_time_param, closed_loop_decel_time_param} = 80'h0003_01F4_0032_0100_0200;
		{frequency_sign_select_param, overspeed_raw, emergency_stop_input} = 3'b111;
		{pre_excitation_input, external_dc_brake_start, drive_running} = 3'b110;
		speed_ref = 16'hFFFB;
		foreach (cl_exp[i]) begin
			nt(19 + i, cl_exp[i]);
		end
		cyc();
		drive_running = 1;
		nt(29, 0);
		cyc();
		control_method_param = 16'h0009;
		nt(28, 0);
		cyc();
		{clk_en, control_method_param} = 17'h0_0000;
		nt(28, 0);
		cyc();
		clk_en = 1;
		nt(28, 1);
		cyc();
		tally_and_finish();
	end
endmodule // closed_loop_gate_test
`default_nettype wire
